// ===== ssi_top.sv
// Serial controller status, compare, mask and simple shift engines
//
// Our own choices: the plain strobed port and the register addresses.
`include "ssi_regs.svh"
module ssi_top
  import ssi_pkg::*;
(
  input wire logic clk_i,
  input wire logic arst_n_i,
  input wire logic [`SSI_ADDR_W-1:0] reg_addr_i,
  input wire logic [`SSI_DATA_W-1:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [`SSI_DATA_W-1:0] reg_rdata_o,
  input wire logic link_clk_i,
  input wire logic rx_data_i,
  input wire logic tx_frame_i,
  input wire logic rx_frame_i,
  output logic tx_data_o,
  output logic irq_o
);

  ////////////////////////////////////////////////////////////////////////////
  // State

  typedef struct packed {
    logic [3:0] sync1;
    logic [3:0] sync2;
    logic [3:0] prev;
    logic tx_enabled;
    logic rx_enabled;
    ssi_word_t cmp0;
    ssi_word_t cmp1;
    logic [`SSI_IRQ_W-1:0] mask;
    ssi_word_t tx_hold;
    logic tx_hold_full;
    ssi_word_t tx_shift;
    logic [`SSI_BITS_W-1:0] tx_bits;
    ssi_tx_state_t tx_state;
    logic td;
    ssi_word_t tx_cnt;
    ssi_word_t tx_ncnt;
    ssi_word_t rx_cnt;
    ssi_word_t rx_ncnt;
    logic tx_count_done;
    logic rx_count_done;
    logic rx_overrun;
    logic compare_zero;
    logic compare_one;
    logic tx_sync_seen;
    logic rx_sync_seen;
    ssi_word_t rx_shift;
    logic [`SSI_BITS_W-1:0] rx_bits;
    ssi_rx_state_t rx_state;
    ssi_word_t rx_pend;
    logic rx_pend_v;
    ssi_word_t rx_hold;
    logic rx_hold_full;
    logic [`SSI_DATA_W-1:0] rdata;
    logic irq;
  } ssi_state_t;

  ssi_state_t r_reg, r_next;

  ssi_stream_if #(.W(`SSI_WORD_W)) fifo_in ();
  ssi_stream_if #(.W(`SSI_WORD_W)) fifo_out ();

  ////////////////////////////////////////////////////////////////////////////
  // Receive buffer

  // Holding register pulls from the FIFO only while it is empty, so a slow
  // reader backs the FIFO up and in turn stalls the pending receive word
  ssi_fifo #(.W(`SSI_WORD_W), .DEPTH(`SSI_FIFO_DEPTH)) u_fifo (
    .clk_i(clk_i),
    .arst_n_i(arst_n_i),
    .wr(fifo_in.snk),
    .rd(fifo_out.src)
  );

  assign fifo_in.valid = r_reg.rx_pend_v;
  assign fifo_in.data = r_reg.rx_pend;
  assign fifo_out.ready = ~r_reg.rx_hold_full;

  ////////////////////////////////////////////////////////////////////////////
  // Helpers

  // One DMA transfer: count down, reload from next count when it runs out
  function automatic ssi_cnt_t cnt_step(input ssi_word_t cnt,
                                        input ssi_word_t ncnt);
    ssi_cnt_t res;
    res.cnt = cnt;
    res.ncnt = ncnt;
    res.done = 1'b0;
    if (cnt != `SSI_RST_WORD) begin
      res.cnt = cnt - ssi_word_t'(1);
      if (res.cnt == `SSI_RST_WORD) begin
        res.done = 1'b1;
        if (ncnt != `SSI_RST_WORD) begin
          res.cnt = ncnt;
          res.ncnt = `SSI_RST_WORD;
        end
      end
    end
    return res;
  endfunction

  logic [`SSI_DATA_W-1:0] status;
  logic [`SSI_IRQ_W-1:0] pending;

  always_comb begin
    status = `SSI_RST_DATA;
    status[`SSI_ST_TX_HOLDING_EMPTY] = ~r_reg.tx_hold_full;
    status[`SSI_ST_TX_ALL_SENT] = ~r_reg.tx_hold_full &
                              (r_reg.tx_state == SSI_TX_IDLE);
    status[`SSI_ST_TX_COUNT_DONE] = r_reg.tx_count_done;
    status[`SSI_ST_TX_BUFFERS_DRAINED] = (r_reg.tx_cnt == `SSI_RST_WORD) &&
                             (r_reg.tx_ncnt == `SSI_RST_WORD);
    status[`SSI_ST_RX_HOLDING_FULL] = r_reg.rx_hold_full;
    status[`SSI_ST_OVR] = r_reg.rx_overrun;
    status[`SSI_ST_RX_COUNT_DONE] = r_reg.rx_count_done;
    status[`SSI_ST_RX_BUFFERS_FULL] = (r_reg.rx_cnt == `SSI_RST_WORD) &&
                             (r_reg.rx_ncnt == `SSI_RST_WORD);
    status[`SSI_ST_CP0] = r_reg.compare_zero;
    status[`SSI_ST_CP1] = r_reg.compare_one;
    status[`SSI_ST_TX_SYNC_SEEN] = r_reg.tx_sync_seen;
    status[`SSI_ST_RX_SYNC_SEEN] = r_reg.rx_sync_seen;
    status[`SSI_ST_TX_ENABLED] = r_reg.tx_enabled;
    status[`SSI_ST_RX_ENABLED] = r_reg.rx_enabled;
    pending = status[`SSI_IRQ_W-1:0] & r_reg.mask;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Next state

  always_comb begin
    logic sclk_rise;
    logic sclk_fall;
    logic txf_rise;
    logic rxf_rise;
    logic st_rd;
    logic wr_tx_cnt;
    logic wr_rx_cnt;
    logic tx_done_set;
    logic rx_done_set;
    logic ovr_set;
    logic cp0_set;
    logic cp1_set;
    ssi_word_t word;
    ssi_cnt_t step;
    sclk_rise = 1'b0;
    sclk_fall = 1'b0;
    txf_rise = 1'b0;
    rxf_rise = 1'b0;
    st_rd = 1'b0;
    wr_tx_cnt = 1'b0;
    wr_rx_cnt = 1'b0;
    tx_done_set = 1'b0;
    rx_done_set = 1'b0;
    ovr_set = 1'b0;
    cp0_set = 1'b0;
    cp1_set = 1'b0;
    word = `SSI_RST_WORD;
    step = '0;
    r_next = r_reg;

    // Pins cross in two stages; edges are found on the second stage only
    r_next.sync1 = {rx_frame_i, tx_frame_i, rx_data_i, link_clk_i};
    r_next.sync2 = r_reg.sync1;
    r_next.prev = r_reg.sync2;
    sclk_rise = r_reg.sync2[`SSI_PIN_SCLK] & ~r_reg.prev[`SSI_PIN_SCLK];
    sclk_fall = ~r_reg.sync2[`SSI_PIN_SCLK] & r_reg.prev[`SSI_PIN_SCLK];
    txf_rise = r_reg.sync2[`SSI_PIN_TXF] & ~r_reg.prev[`SSI_PIN_TXF];
    rxf_rise = r_reg.sync2[`SSI_PIN_RXF] & ~r_reg.prev[`SSI_PIN_RXF];

    // Transmit: holding word moves to the shifter when it falls idle
    if (r_reg.tx_state == SSI_TX_IDLE && r_reg.tx_hold_full &&
        r_reg.tx_enabled) begin
      r_next.tx_shift = r_reg.tx_hold;
      r_next.tx_hold_full = 1'b0;
      r_next.tx_bits = `SSI_BITS_ZERO;
      r_next.tx_state = SSI_TX_SHIFT;
      step = cnt_step(r_reg.tx_cnt, r_reg.tx_ncnt);
      r_next.tx_cnt = step.cnt;
      r_next.tx_ncnt = step.ncnt;
      tx_done_set = step.done;
    end

    case (r_reg.tx_state)
      SSI_TX_IDLE: begin
      end
      SSI_TX_SHIFT: begin
        // Most significant bit first, changed on the falling link edge
        if (sclk_fall) begin
          r_next.td = r_reg.tx_shift[`SSI_WORD_W-1];
          r_next.tx_shift = {r_reg.tx_shift[`SSI_WORD_W-2:0], 1'b0};
          r_next.tx_bits = r_reg.tx_bits + `SSI_BITS_W'(1);
          if (r_reg.tx_bits == `SSI_LAST_BIT) begin
            r_next.tx_state = SSI_TX_IDLE;
          end
        end
      end
      default: begin
        r_next.tx_state = SSI_TX_IDLE;
      end
    endcase

    // Receive: a frame edge opens a word, sampled on rising link edges
    if (fifo_in.ready && r_reg.rx_pend_v) begin
      r_next.rx_pend_v = 1'b0;
    end

    case (r_reg.rx_state)
      SSI_RX_WAIT: begin
        if (rxf_rise && r_reg.rx_enabled) begin
          r_next.rx_state = SSI_RX_SHIFT;
          r_next.rx_bits = `SSI_BITS_ZERO;
        end
      end
      SSI_RX_SHIFT: begin
        if (!r_reg.rx_enabled) begin
          r_next.rx_state = SSI_RX_WAIT;
        end else if (sclk_rise) begin
          word = {r_reg.rx_shift[`SSI_WORD_W-2:0],
                  r_reg.sync2[`SSI_PIN_RXD]};
          r_next.rx_shift = word;
          r_next.rx_bits = r_reg.rx_bits + `SSI_BITS_W'(1);
          if (r_reg.rx_bits == `SSI_LAST_BIT) begin
            r_next.rx_state = SSI_RX_WAIT;
            r_next.rx_pend = word;
            r_next.rx_pend_v = 1'b1;
            // Stalled word still waiting is lost and flagged
            ovr_set = r_reg.rx_pend_v & ~fifo_in.ready;
            cp0_set = (word == r_reg.cmp0);
            cp1_set = (word == r_reg.cmp1);
          end
        end
      end
      default: begin
        r_next.rx_state = SSI_RX_WAIT;
      end
    endcase

    // Holding register takes the FIFO head whenever it is empty
    if (fifo_out.valid && !r_reg.rx_hold_full) begin
      r_next.rx_hold = fifo_out.data;
      r_next.rx_hold_full = 1'b1;
      step = cnt_step(r_reg.rx_cnt, r_reg.rx_ncnt);
      r_next.rx_cnt = step.cnt;
      r_next.rx_ncnt = step.ncnt;
      rx_done_set = step.done;
    end

    // Register writes
    if (reg_wr_i) begin
      case (reg_addr_i)
        `SSI_OFF_CTRL: begin
          r_next.tx_enabled = reg_wdata_i[`SSI_CTRL_TX_ENABLED];
          r_next.rx_enabled = reg_wdata_i[`SSI_CTRL_RX_ENABLED];
        end
        `SSI_OFF_TXHOLD: begin
          r_next.tx_hold = reg_wdata_i[`SSI_WORD_W-1:0];
          r_next.tx_hold_full = 1'b1;
        end
        `SSI_OFF_CMP0: r_next.cmp0 = reg_wdata_i[`SSI_WORD_W-1:0];
        `SSI_OFF_CMP1: r_next.cmp1 = reg_wdata_i[`SSI_WORD_W-1:0];
        `SSI_OFF_IER: begin
          r_next.mask = r_reg.mask | reg_wdata_i[`SSI_IRQ_W-1:0];
        end
        `SSI_OFF_IDR: begin
          r_next.mask = r_reg.mask & ~reg_wdata_i[`SSI_IRQ_W-1:0];
        end
        `SSI_OFF_TXCNT: begin
          r_next.tx_cnt = reg_wdata_i[`SSI_WORD_W-1:0];
          wr_tx_cnt = 1'b1;
        end
        `SSI_OFF_TXNCNT: begin
          r_next.tx_ncnt = reg_wdata_i[`SSI_WORD_W-1:0];
          wr_tx_cnt = 1'b1;
        end
        `SSI_OFF_RXCNT: begin
          r_next.rx_cnt = reg_wdata_i[`SSI_WORD_W-1:0];
          wr_rx_cnt = 1'b1;
        end
        `SSI_OFF_RXNCNT: begin
          r_next.rx_ncnt = reg_wdata_i[`SSI_WORD_W-1:0];
          wr_rx_cnt = 1'b1;
        end
        default: begin
        end
      endcase
    end

    // Register reads; data stand in the next cycle only
    r_next.rdata = `SSI_RST_DATA;
    if (reg_rd_i) begin
      case (reg_addr_i)
        `SSI_OFF_CTRL: begin
          r_next.rdata[`SSI_CTRL_TX_ENABLED] = r_reg.tx_enabled;
          r_next.rdata[`SSI_CTRL_RX_ENABLED] = r_reg.rx_enabled;
        end
        `SSI_OFF_RXHOLD: begin
          r_next.rdata[`SSI_WORD_W-1:0] = r_reg.rx_hold;
          // Only a full register is emptied, so a word landing now is kept
          if (r_reg.rx_hold_full) begin
            r_next.rx_hold_full = 1'b0;
          end
        end
        `SSI_OFF_CMP0: r_next.rdata[`SSI_WORD_W-1:0] = r_reg.cmp0;
        `SSI_OFF_CMP1: r_next.rdata[`SSI_WORD_W-1:0] = r_reg.cmp1;
        `SSI_OFF_STATUS: begin
          r_next.rdata = status;
          st_rd = 1'b1;
        end
        `SSI_OFF_IMR: r_next.rdata[`SSI_IRQ_W-1:0] = r_reg.mask;
        `SSI_OFF_TXCNT: r_next.rdata[`SSI_WORD_W-1:0] = r_reg.tx_cnt;
        `SSI_OFF_TXNCNT: r_next.rdata[`SSI_WORD_W-1:0] = r_reg.tx_ncnt;
        `SSI_OFF_RXCNT: r_next.rdata[`SSI_WORD_W-1:0] = r_reg.rx_cnt;
        `SSI_OFF_RXNCNT: r_next.rdata[`SSI_WORD_W-1:0] = r_reg.rx_ncnt;
        default: begin
        end
      endcase
    end

    // Sticky flags: clear first, a same-cycle event still sets
    r_next.tx_count_done = (r_reg.tx_count_done & ~wr_tx_cnt) |
                           tx_done_set;
    r_next.rx_count_done = (r_reg.rx_count_done & ~wr_rx_cnt) |
                           rx_done_set;
    r_next.rx_overrun = (r_reg.rx_overrun & ~st_rd) | ovr_set;
    r_next.compare_zero = (r_reg.compare_zero & ~st_rd) | cp0_set;
    r_next.compare_one = (r_reg.compare_one & ~st_rd) | cp1_set;
    r_next.tx_sync_seen = (r_reg.tx_sync_seen & ~st_rd) | txf_rise;
    r_next.rx_sync_seen = (r_reg.rx_sync_seen & ~st_rd) | rxf_rise;

    r_next.irq = |pending;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registers and outputs

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      r_reg <= '0;
    end else begin
      r_reg <= r_next;
    end
  end

  assign reg_rdata_o = r_reg.rdata;
  assign tx_data_o = r_reg.td;
  assign irq_o = r_reg.irq;

endmodule // ssi_top

// ===== ssi_regs.svh
// Register map, field positions and reset values of the serial status block
//
// How it works
// - Compare value 0 register, read-write, data in bits 15..0, rest zero.
// - Compare value 1 register, read-write, data in bits 15..0, rest zero.
// - Transmit holding empty reads 1 when holding register empty, else 0.
// - Transmit all sent reads 1 only when holding and shifter are empty.
// - Tx count done sets when tx count reaches 0; tx count writes clear it.
// - Tx buffers drained reads 1 when tx count and next count both 0.
// - Receive holding full reads 1 once a word is loaded, 0 when empty.
// - Overrun sets when a word lands before the previous one was taken.
// - Rx count done sets when rx count reaches 0; rx count writes clear it.
// - Rx buffers full reads 1 when rx count and next count are both 0.
// - Compare zero flag sets on a match with value 0, status read clears.
// - Compare one flag sets on a match with value 1, status read clears.
// - Tx sync flag sets on a tx frame edge, cleared by a status read.
// - Rx sync flag sets on an rx frame edge, cleared by a status read.
// - Status bits 16 and 17 show transmitter and receiver enabled.
// - Writing 1 to an enable-set bit enables that source; 0 does nothing.
// - Writing 1 to a disable-set bit disables that source; 0 does nothing.
// - Mask view reads 1 for each enabled source, 0 for each disabled.
`ifndef SSI_REGS_SVH
`define SSI_REGS_SVH

`define SSI_ADDR_W 8
`define SSI_DATA_W 32
`define SSI_WORD_W 16
`define SSI_BITS_W 5
`define SSI_IRQ_W 12
`define SSI_FIFO_DEPTH 16

`define SSI_OFF_CTRL 8'h00
`define SSI_OFF_TXHOLD 8'h04
`define SSI_OFF_RXHOLD 8'h08
`define SSI_OFF_CMP0 8'h0c
`define SSI_OFF_CMP1 8'h10
`define SSI_OFF_STATUS 8'h14
`define SSI_OFF_IER 8'h18
`define SSI_OFF_IDR 8'h1c
`define SSI_OFF_IMR 8'h20
`define SSI_OFF_TXCNT 8'h24
`define SSI_OFF_TXNCNT 8'h28
`define SSI_OFF_RXCNT 8'h2c
`define SSI_OFF_RXNCNT 8'h30

`define SSI_CTRL_TX_ENABLED 0
`define SSI_CTRL_RX_ENABLED 1

`define SSI_ST_TX_HOLDING_EMPTY 0
`define SSI_ST_TX_ALL_SENT 1
`define SSI_ST_TX_COUNT_DONE 2
`define SSI_ST_TX_BUFFERS_DRAINED 3
`define SSI_ST_RX_HOLDING_FULL 4
`define SSI_ST_OVR 5
`define SSI_ST_RX_COUNT_DONE 6
`define SSI_ST_RX_BUFFERS_FULL 7
`define SSI_ST_CP0 8
`define SSI_ST_CP1 9
`define SSI_ST_TX_SYNC_SEEN 10
`define SSI_ST_RX_SYNC_SEEN 11
`define SSI_ST_TX_ENABLED 16
`define SSI_ST_RX_ENABLED 17

`define SSI_PIN_SCLK 0
`define SSI_PIN_RXD 1
`define SSI_PIN_TXF 2
`define SSI_PIN_RXF 3

`define SSI_RST_WORD 16'h0000
`define SSI_RST_MASK 12'h000
`define SSI_RST_DATA 32'h0000_0000
`define SSI_LAST_BIT 5'h0f
`define SSI_BITS_ZERO 5'h00

`endif

// ===== ssi_pkg.sv
// Types shared by the serial status block
package ssi_pkg;
  `include "ssi_regs.svh"

  typedef enum logic {SSI_TX_IDLE, SSI_TX_SHIFT} ssi_tx_state_t;
  typedef enum logic {SSI_RX_WAIT, SSI_RX_SHIFT} ssi_rx_state_t;

  typedef logic [`SSI_WORD_W-1:0] ssi_word_t;

  typedef struct packed {
    ssi_word_t cnt;
    ssi_word_t ncnt;
    logic done;
  } ssi_cnt_t;
endpackage

// ===== ssi_stream_if.sv
// Valid-ready word stream between the block's own modules
interface ssi_stream_if #(parameter int W = 16);
  logic valid;
  logic ready;
  logic [W-1:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface

// ===== ssi_mem.sv
// Small word memory with registered read data and write-first bypass
module ssi_mem #(
  parameter int W = 16,
  parameter int DEPTH = 16,
  parameter int AW = $clog2(DEPTH)
) (
  input wire logic clk_i,
  input wire logic arst_n_i,
  input wire logic we_i,
  input wire logic [AW-1:0] waddr_i,
  input wire logic [W-1:0] wdata_i,
  input wire logic [AW-1:0] raddr_i,
  output logic [W-1:0] rdata_o
);
  logic [W-1:0] mem_reg [DEPTH];

  always_ff @(posedge clk_i) begin
    if (we_i) begin
      mem_reg[waddr_i] <= wdata_i;
    end
  end

  // Bypass keeps a word written into an empty FIFO visible one cycle later
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rdata_o <= '0;
    end else if (we_i && (waddr_i == raddr_i)) begin
      rdata_o <= wdata_i;
    end else begin
      rdata_o <= mem_reg[raddr_i];
    end
  end
endmodule // ssi_mem

// ===== ssi_fifo.sv
// Receive word FIFO with valid and ready on both sides
module ssi_fifo #(
  parameter int W = 16,
  parameter int DEPTH = 16
) (
  input wire logic clk_i,
  input wire logic arst_n_i,
  ssi_stream_if.snk wr,
  ssi_stream_if.src rd
);
  localparam int AW = $clog2(DEPTH);
  localparam int CW = AW + 1;

  typedef struct packed {
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [CW-1:0] count;
  } ssi_fifo_state_t;

  ssi_fifo_state_t r_reg, r_next;
  logic push;
  logic pop;

  assign wr.ready = (r_reg.count != CW'(DEPTH));
  assign rd.valid = (r_reg.count != '0);
  assign push = wr.valid & wr.ready;
  assign pop = rd.valid & rd.ready;

  always_comb begin
    r_next = r_reg;
    if (push) begin
      r_next.wp = r_reg.wp + AW'(1);
    end
    if (pop) begin
      r_next.rp = r_reg.rp + AW'(1);
    end
    r_next.count = r_reg.count + CW'(push) - CW'(pop);
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      r_reg <= '0;
    end else begin
      r_reg <= r_next;
    end
  end

  // Read address runs one pop ahead so the head word is always registered
  ssi_mem #(.W(W), .DEPTH(DEPTH), .AW(AW)) u_mem (
    .clk_i(clk_i),
    .arst_n_i(arst_n_i),
    .we_i(push),
    .waddr_i(r_reg.wp),
    .wdata_i(wr.data),
    .raddr_i(r_next.rp),
    .rdata_o(rd.data)
  );
endmodule // ssi_fifo

// ===== ssi_top_chk.sv
// Register port checker for the serial status block
`include "ssi_regs.svh"
module ssi_top_chk
  import ssi_pkg::*;
(
  input wire logic clk_i,
  input wire logic arst_n_i,
  input wire logic [`SSI_ADDR_W-1:0] reg_addr_i,
  input wire logic [`SSI_DATA_W-1:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [`SSI_DATA_W-1:0] reg_rdata_o,
  input wire logic irq_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!arst_n_i);
  sequence s_wr(logic [7:0] a);
    reg_wr_i && reg_addr_i == a;
  endsequence
  sequence s_rd(logic [7:0] a);
    reg_rd_i && reg_addr_i == a;
  endsequence
  ////////////////////////////////////////////////////////////////////////////
  a_cmp0_readback: assert property (
    s_wr(`SSI_OFF_CMP0) ##1 s_rd(`SSI_OFF_CMP0)
    |=> reg_rdata_o == ($past(reg_wdata_i, 2) & 32'h0000_ffff))
    else $error("compare 0 read back wrong");
  a_cmp1_readback: assert property (
    s_wr(`SSI_OFF_CMP1) ##1 s_rd(`SSI_OFF_CMP1)
    |=> reg_rdata_o == ($past(reg_wdata_i, 2) & 32'h0000_ffff))
    else $error("compare 1 read back wrong");
  a_enable_mirror: assert property (
    s_wr(`SSI_OFF_CTRL) ##1 s_rd(`SSI_OFF_STATUS)
    |=> ((reg_rdata_o ^ ($past(reg_wdata_i, 2) << 16)) & 32'h0003_0000) == 0)
    else $error("enable bits do not follow control");
  a_status_reserved: assert property (
    s_rd(`SSI_OFF_STATUS) |=> (reg_rdata_o & 32'hfffc_f000) == 32'h0)
    else $error("reserved status bits set");
  // Full disable first, so the view must equal the enable word alone
  a_mask_readback: assert property (
    (s_wr(`SSI_OFF_IDR) and reg_wdata_i[11:0] == 12'hfff)
    ##1 s_wr(`SSI_OFF_IER) ##1 s_rd(`SSI_OFF_IMR)
    |=> reg_rdata_o == ($past(reg_wdata_i, 2) & 32'hfff))
    else $error("mask view wrong");
  // Interrupt is registered from the mask, so it drops one edge later
  a_irq_masked: assert property (
    (s_wr(`SSI_OFF_IDR) and reg_wdata_i[11:0] == 12'hfff) |=> ##1 !irq_o)
    else $error("interrupt high with every source disabled");
  a_tx_count_clear: assert property (
    (s_wr(`SSI_OFF_TXCNT) and reg_wdata_i[15:0] > 16'h0001)
    ##1 s_rd(`SSI_OFF_STATUS) |=> reg_rdata_o[3:2] == 2'b00)
    else $error("tx count flags wrong after count write");
  a_rx_count_clear: assert property (
    (s_wr(`SSI_OFF_RXCNT) and reg_wdata_i[15:0] > 16'h0001)
    ##1 s_rd(`SSI_OFF_STATUS) |=> reg_rdata_o[7:6] == 2'b00)
    else $error("rx count flags wrong after count write");
  a_wo_read_zero: assert property (
    reg_rd_i && (reg_addr_i == `SSI_OFF_IER || reg_addr_i == `SSI_OFF_IDR
    || reg_addr_i == `SSI_OFF_TXHOLD) |=> reg_rdata_o == 32'h0)
    else $error("write-only register read not zero");
endmodule // ssi_top_chk

bind ssi_top ssi_top_chk u_chk (.clk_i(clk_i), .arst_n_i(arst_n_i),
  .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i),
  .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .irq_o(irq_o));

// ===== ssi_link_model.sv
// Behavioural serial codec on the far side of the link
module ssi_link_model (
  output logic link_clk_o,
  output logic rx_data_o,
  output logic tx_frame_o,
  output logic rx_frame_o,
  input wire logic tx_data_i
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    link_clk_o = 1'b0;
    rx_data_o = 1'b0;
    tx_frame_o = 1'b0;
    rx_frame_o = 1'b0;
  end
  // Frame strobes drop after the first link clock pulse; 17 cycles catch all 16 tx bits
  task automatic xfer(input logic [15:0] rw, output logic [15:0] tw);
    #13;
    tx_frame_o = 1'b1;
    rx_frame_o = 1'b1;
    rx_data_o = rw[15];
    #300;
    for (int i = 0; i < 17; i++) begin
      link_clk_o = 1'b1;
      if (i > 0) tw = {tw[14:0], tx_data_i};
      #200;
      link_clk_o = 1'b0;
      tx_frame_o = 1'b0;
      rx_frame_o = 1'b0;
      if (i < 15) rx_data_o = rw[14-i];
      #200;
    end
    // Released line shows the inverse so a stale bit cannot pass
    rx_data_o = ~rx_data_o;
    #400;
  endtask
endmodule // ssi_link_model

// ===== ssi_top_test.sv
// Register-level bench for the serial status block
`include "ssi_regs.svh"
module ssi_top_test
  import ssi_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_i = 1'b0;
  logic arst_n_i = 1'b0;
  logic [7:0] reg_addr_i = 8'h00;
  logic [31:0] reg_wdata_i = 32'h0;
  logic reg_wr_i = 1'b0;
  logic reg_rd_i = 1'b0;
  logic [31:0] reg_rdata_o;
  logic link_clk_i, rx_data_i, tx_frame_i, rx_frame_i, tx_data_o, irq_o;
  int failures = 0;
  int tests_run = 0;
  logic [31:0] d;
  logic [15:0] tw;
  logic [15:0] w [19];
  always #25 clk_i = ~clk_i;
  ssi_top u_dut (.clk_i(clk_i), .arst_n_i(arst_n_i), .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
    .reg_rdata_o(reg_rdata_o), .link_clk_i(link_clk_i), .rx_data_i(rx_data_i),
    .tx_frame_i(tx_frame_i), .rx_frame_i(rx_frame_i), .tx_data_o(tx_data_o),
    .irq_o(irq_o));
  ssi_link_model u_link (.link_clk_o(link_clk_i), .rx_data_o(rx_data_i),
    .tx_frame_o(tx_frame_i), .rx_frame_o(rx_frame_i), .tx_data_i(tx_data_o));
  ////////////////////////////////////////////////////////////////////////////
  task chk(string n, logic [31:0] e, logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      failures++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask
  // Strobe stays up until the next call or idle, never set twice per edge
  task wr(logic [7:0] a, logic [31:0] v);
    reg_addr_i <= a;
    reg_wdata_i <= v;
    reg_wr_i <= 1'b1;
    reg_rd_i <= 1'b0;
    @(posedge clk_i);
  endtask
  task rd(logic [7:0] a, output logic [31:0] v);
    reg_addr_i <= a;
    reg_rd_i <= 1'b1;
    reg_wr_i <= 1'b0;
    @(posedge clk_i);
    reg_rd_i <= 1'b0;
    @(negedge clk_i);
    v = reg_rdata_o;
    @(posedge clk_i);
  endtask
  task rc(logic [7:0] a, logic [31:0] e, string n);
    rd(a, d);
    chk(n, e, d);
  endtask
  task idle(int n);
    reg_wr_i <= 1'b0;
    reg_rd_i <= 1'b0;
    repeat (n) @(posedge clk_i);
  endtask
  task chk_irq(logic e);
    @(negedge clk_i);
    chk("irq", {31'h0, e}, {31'h0, irq_o});
    @(posedge clk_i);
  endtask
  task frame(logic [15:0] rw, output logic [15:0] t);
    idle(1);
    u_link.xfer(rw, t);
    @(posedge clk_i);
  endtask
  task fin(string n);
    $display("test %s done", n);
  endtask
  task conclude;
    $display("checks %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    #500us;
    failures++;
    conclude;
  end
  initial begin
    repeat (6) @(posedge clk_i);
    arst_n_i <= 1'b1;
    @(posedge clk_i);
    rc(`SSI_OFF_STATUS, 32'h8b, "status");
    rc(`SSI_OFF_IMR, 32'h0, "mask");
    rc(`SSI_OFF_CMP0, 32'h0, "cmp0");
    rc(8'hfc, 32'h0, "unmapped");
    rc(`SSI_OFF_IER, 32'h0, "ier");
    fin("reset");
    wr(`SSI_OFF_CMP0, 32'h1234abcd);
    rc(`SSI_OFF_CMP0, 32'habcd, "cmp0");
    wr(`SSI_OFF_CMP1, 32'hffff5a5a);
    rc(`SSI_OFF_CMP1, 32'h5a5a, "cmp1");
    fin("compare");
    wr(`SSI_OFF_IDR, 32'hfff);
    wr(`SSI_OFF_IER, 32'h0a5);
    rc(`SSI_OFF_IMR, 32'h0a5, "mask");
    wr(`SSI_OFF_IER, 32'h0);
    rc(`SSI_OFF_IMR, 32'h0a5, "mask");
    wr(`SSI_OFF_IDR, 32'h005);
    rc(`SSI_OFF_IMR, 32'h0a0, "mask");
    idle(3);
    chk_irq(1'b1);
    wr(`SSI_OFF_IDR, 32'h080);
    idle(3);
    chk_irq(1'b0);
    wr(`SSI_OFF_IER, 32'h080);
    idle(2);
    chk_irq(1'b1);
    wr(`SSI_OFF_IDR, 32'hfff);
    idle(2);
    chk_irq(1'b0);
    fin("mask");
    wr(`SSI_OFF_CTRL, 32'h3);
    rc(`SSI_OFF_STATUS, 32'h3008b, "status");
    wr(`SSI_OFF_TXCNT, 32'h2);
    rc(`SSI_OFF_STATUS, 32'h30083, "status");
    wr(`SSI_OFF_RXCNT, 32'h2);
    rc(`SSI_OFF_STATUS, 32'h30003, "status");
    wr(`SSI_OFF_TXCNT, 32'h1);
    wr(`SSI_OFF_RXCNT, 32'h1);
    wr(`SSI_OFF_TXHOLD, 32'ha5c3);
    rc(`SSI_OFF_STATUS, 32'h30000, "status");
    idle(4);
    rc(`SSI_OFF_STATUS, 32'h3000d, "status");
    frame(16'habcd, tw);
    chk("tx word", 32'ha5c3, {16'h0, tw});
    idle(10);
    rc(`SSI_OFF_STATUS, 32'h30ddf, "status");
    rc(`SSI_OFF_STATUS, 32'h300df, "status");
    rc(`SSI_OFF_RXHOLD, 32'habcd, "rx word");
    rc(`SSI_OFF_STATUS, 32'h300cf, "status");
    fin("link");
    // Holding, 16 FIFO places and the pending word fill before the loss
    for (int i = 0; i < 19; i++) begin
      w[i] = (i == 5) ? 16'h5a5a : 16'h0100 + 16'(i);
      frame(w[i], tw);
    end
    rd(`SSI_OFF_STATUS, d);
    chk("overrun", 32'h220, d & 32'h220);
    rd(`SSI_OFF_STATUS, d);
    chk("cleared", 32'h0, d & 32'h220);
    for (int j = 0; j < 18; j++) begin
      idle(8);
      rc(`SSI_OFF_RXHOLD, {16'h0, w[(j < 17) ? j : 18]}, "rx word");
    end
    idle(8);
    rd(`SSI_OFF_STATUS, d);
    chk("rx empty", 32'h0, d & 32'h10);
    fin("overrun");
    wr(`SSI_OFF_CTRL, 32'h1);
    frame(16'h5a5a, tw);
    idle(10);
    rd(`SSI_OFF_STATUS, d);
    chk("rx off", 32'h10800, d & 32'h30a10);
    fin("rx off");
    // Next-count writes clear done; a count run out reloads from next count
    wr(`SSI_OFF_TXNCNT, 32'h3);
    rd(`SSI_OFF_STATUS, d);
    chk("tx next", 32'hc0, d & 32'hcc);
    wr(`SSI_OFF_RXNCNT, 32'h5);
    wr(`SSI_OFF_TXCNT, 32'h1);
    wr(`SSI_OFF_TXHOLD, 32'h1111);
    idle(2);
    rd(`SSI_OFF_STATUS, d);
    chk("reload", 32'h04, d & 32'hcc);
    rc(`SSI_OFF_TXCNT, 32'h3, "tx count");
    rc(`SSI_OFF_TXNCNT, 32'h0, "tx next count");
    rc(`SSI_OFF_RXNCNT, 32'h5, "rx next count");
    fin("reload");
    conclude;
  end
endmodule // ssi_top_test
